// ===== common/afs_pkg.sv
package afs_pkg;

	// Serial word layout
	localparam int unsigned WORD_W     = 16;
	localparam int unsigned RESULT_W   = 12;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned FIFO_CNT_W = 4;

	// Command nibbles and special words
	localparam logic [3:0]  CMD_CONFIG    = 4'hA;
	localparam logic [3:0]  CMD_SLEEP     = 4'h8;
	localparam logic [3:0]  CMD_READ_CFG  = 4'h9;
	localparam logic [3:0]  CMD_READ_FIFO = 4'hE;
	localparam logic [15:0] WORD_HOST_SEL = 16'hA000;
	localparam logic [15:0] WORD_SW_SLEEP = 16'h8000;

	// Configuration word fields and reset value
	localparam int unsigned CFG_THR_LSB  = 0;
	localparam int unsigned CFG_DIV_BIT  = 2;
	localparam int unsigned CFG_SEQ_LSB  = 3;
	localparam int unsigned CFG_MODE_LSB = 5;
	localparam int unsigned CFG_EXT_BIT  = 7;
	localparam logic [11:0] CFG_RESET    = 12'h000;

	// Conversion modes
	localparam logic [1:0] MODE_SINGLE = 2'b00;
	localparam logic [1:0] MODE_REPEAT = 2'b01;
	localparam logic [1:0] MODE_SWEEP  = 2'b10;
	localparam logic [1:0] MODE_RSWEEP = 2'b11;

	// Conversion timing in serial clocks
	localparam logic [5:0] CONV_CLOCKS   = 6'h0E;
	localparam logic [5:0] CONV_OVERHEAD = 6'h04;

	// Power-down recovery time
	localparam int unsigned CLK_PERIOD_NS   = 40;
	localparam int unsigned RECOVERY_MS     = 20;
	localparam int unsigned RECOVERY_CYCLES =
		RECOVERY_MS * 1000000 / CLK_PERIOD_NS;

	typedef enum logic {CONV_IDLE, CONV_RUN} afs_conv_type;

	// Entries that raise the interrupt, per threshold code
	function automatic logic [3:0] thrCount(input logic [1:0] sel);
		case (sel)
			2'b00: thrCount = 4'h8;
			2'b01: thrCount = 4'h6;
			2'b10: thrCount = 4'h4;
			default: thrCount = 4'h2;
		endcase
	endfunction

	// Serial clocks per conversion: overhead plus 14 per divider step
	function automatic logic [5:0] convLength(input logic divTwo);
		convLength = divTwo ? CONV_OVERHEAD + CONV_CLOCKS + CONV_CLOCKS
			: CONV_OVERHEAD + CONV_CLOCKS;
	endfunction

	// Channel of a sweep sequence step
	function automatic logic [2:0] seqChan(input logic [1:0] sel,
		input logic [2:0] idx);
		case (sel)
			2'b00: seqChan = {1'b0, idx[1:0]};
			2'b01: seqChan = idx;
			2'b10: seqChan = {idx[1:0], 1'b0};
			default: seqChan = {idx[1:0], 1'b1};
		endcase
	endfunction

endpackage

// ===== verilog/afs_sequencer.sv
`timescale 1ns/1ps

module afs_fifo #(
	parameter int unsigned WIDTH = 12,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       rst,
	// Control
	input  wire logic                       flush,
	output logic      [$clog2(DEPTH):0]     count,
	// Fill side
	input  wire logic                       inValid,
	input  wire logic [WIDTH-1:0]           inData,
	output logic                            inReady,
	// Drain side
	output logic                            outValid,
	output logic      [WIDTH-1:0]           outData,
	input  wire logic                       outReady
);
	localparam int unsigned PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    rdPtr, wrPtr, next_rdPtr, next_wrPtr;
	logic [PW:0]      next_count;
	logic             push, pop;

	assign inReady  = (count != DEPTH[PW:0]);
	assign outValid = (count != '0);
	assign outData  = mem[rdPtr];
	assign push     = inValid && (inReady || flush);
	assign pop      = outReady && outValid && !flush;

	// Pointer arithmetic; a flush in the same cycle as a push keeps the push
	always_comb begin
		next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
		next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
		next_count = count + PW'(push) - PW'(pop);
		if (flush) begin
			next_rdPtr = '0;
			next_wrPtr = push ? PW'(1) : '0;
			next_count = push ? (PW+1)'(1) : '0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdPtr <= '0;
			wrPtr <= '0;
			count <= '0;
		end else begin
			rdPtr <= next_rdPtr;
			wrPtr <= next_wrPtr;
			count <= next_count;
		end
	end

	// Storage has no reset, only the pointers matter
	always_ff @(posedge ref_clk) begin
		if (push)
			mem[flush ? '0 : wrPtr] <= inData;
	end
endmodule // afs_fifo

module afs_sequencer #(
	parameter int unsigned RECOVERY_CYCLES = afs_pkg::RECOVERY_CYCLES
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Serial link
	input  wire logic        sclk,
	input  wire logic        chipSelN,
	input  wire logic        frameSync,
	input  wire logic        csAsFrame,
	input  wire logic        serialIn,
	output logic             serialOut,
	output logic             serialOutEnN,
	// Conversion and sleep controls
	input  wire logic        conversionTriggerN,
	input  wire logic        hwSleepPin,
	// Analog core
	input  wire logic [11:0] adcResult,
	output logic      [2:0]  sampleChannel,
	output logic             converterOn,
	output logic             referenceOn,
	// Status
	output logic             intN,
	output logic             firstResultInvalid,
	output logic             recovered,
	output logic             hostSelected,
	output logic      [11:0] configWord
);
	afs_pkg::afs_conv_type convState, next_convState;
	logic        sclkQ, csQ, fsQ, trigQ;
	logic [3:0]  bitCnt, next_bitCnt;
	logic [15:0] inShift, next_inShift, outShift, next_outShift;
	logic        driving, next_driving, intServe, next_intServe;
	logic        intActive, next_intActive, intPending, next_intPending;
	logic        armed, next_armed, stale, next_stale;
	logic        swSleep, next_swSleep, wakeFirst, next_wakeFirst;
	logic [2:0]  chan, next_chan, seqIdx, next_seqIdx;
	logic [2:0]  next_sampleChannel;
	logic [5:0]  convCnt, next_convCnt;
	logic [11:0] lastResult, next_lastResult, next_configWord;
	logic [19:0] recovCnt, next_recovCnt;
	logic        next_firstInvalid, next_hostSelected;
	logic        sclkRise, sampleEdge, frameStart, csRise, trigRise;
	logic        inFrame, awake, wordDone, cfgWrite, convDone, fifoMode;
	logic        fifoPush, fifoPop, fifoFlush, fifoInReady, fifoOutValid;
	logic [15:0] word;
	logic [3:0]  nibble, fifoCount;
	logic [11:0] fifoHead;
	logic [1:0]  mode;

	// Edge detection; inputs are already synchronous to ref_clk
	assign sclkRise   = sclk && !sclkQ;
	assign sampleEdge = csAsFrame ? sclkRise : (!sclk && sclkQ);
	assign inFrame    = !chipSelN;
	assign frameStart = (inFrame && csQ) || (frameSync && !fsQ && inFrame);
	assign csRise     = chipSelN && !csQ;
	assign trigRise   = conversionTriggerN && !trigQ;
	assign awake      = !swSleep && !hwSleepPin;
	assign mode       = configWord[afs_pkg::CFG_MODE_LSB +: 2];
	assign fifoMode   = (mode != afs_pkg::MODE_SINGLE);
	assign word       = {inShift[14:0], serialIn};
	assign nibble     = {inShift[2:0], serialIn};
	assign wordDone   = sampleEdge && inFrame && (bitCnt == 4'hF);
	assign cfgWrite   = wordDone && (word[15:12] == afs_pkg::CMD_CONFIG)
		&& (word != afs_pkg::WORD_HOST_SEL);
	assign convDone   = (convState == afs_pkg::CONV_RUN) && sclkRise
		&& (convCnt + 6'h01 == afs_pkg::convLength(
		configWord[afs_pkg::CFG_DIV_BIT]));
	assign fifoPush   = convDone && fifoMode;
	assign fifoPop    = wordDone && fifoMode
		&& (word[15:12] == afs_pkg::CMD_READ_FIFO) && driving;
	// Stale data is dropped when the next result arrives; a config write or sleep flushes everything
	assign fifoFlush  = cfgWrite || !awake
		|| (stale && fifoPush);

	// Pin-facing outputs; the converter sleeps when idle, deselected and not triggered
	assign serialOut    = outShift[15];
	assign serialOutEnN = !(driving && inFrame);
	assign intN         = !intActive;
	assign referenceOn  = awake;
	assign converterOn  = awake && (inFrame || !conversionTriggerN
		|| convState == afs_pkg::CONV_RUN);
	assign recovered    = (recovCnt == '0);

	// Result FIFO, depth fixed at eight entries
	afs_fifo #(
		.WIDTH (afs_pkg::RESULT_W),
		.DEPTH (afs_pkg::FIFO_DEPTH)
	) u_fifo (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.flush    (fifoFlush),
		.count    (fifoCount),
		.inValid  (fifoPush),
		.inData   (adcResult),
		.inReady  (fifoInReady),
		.outValid (fifoOutValid),
		.outData  (fifoHead),
		.outReady (fifoPop)
	);

	// Next state of link, conversion and power logic
	always_comb begin
		next_bitCnt = bitCnt;
		next_inShift = inShift;
		next_outShift = outShift;
		next_driving = driving && inFrame;
		next_intServe = intServe;
		next_intActive = intActive;
		next_intPending = intPending;
		next_armed = armed;
		next_stale = stale && !fifoFlush;
		next_swSleep = swSleep;
		next_wakeFirst = wakeFirst;
		next_chan = chan;
		next_seqIdx = seqIdx;
		next_sampleChannel = sampleChannel;
		next_convState = convState;
		next_convCnt = convCnt;
		next_lastResult = lastResult;
		next_configWord = configWord;
		next_firstInvalid = firstResultInvalid;
		next_hostSelected = hostSelected;
		next_recovCnt = (recovCnt != '0) ? recovCnt - 20'h0_0001 : recovCnt;
		// Frame start preloads the likely read data
		if (frameStart) begin
			next_bitCnt = '0;
			next_outShift = {fifoMode ? fifoHead : lastResult, 4'h0};
			next_driving = !fifoMode || fifoOutValid;
			next_intActive = 1'b0;
			next_intServe = intPending;
			next_intPending = 1'b0;
			if (swSleep) begin
				next_swSleep = 1'b0;
				next_recovCnt = 20'(RECOVERY_CYCLES);
			end
		end else if (inFrame) begin
			if (sclkRise && bitCnt != 4'h0)
				next_outShift = {outShift[14:0], 1'b0};
			if (sampleEdge) begin
				next_inShift = word;
				next_bitCnt = bitCnt + 4'h1;
			end
			// Command known after four bits
			if (sampleEdge && bitCnt == 4'h3) begin
				next_intServe = 1'b0;
				if (nibble == afs_pkg::CMD_READ_CFG) begin
					next_outShift = {configWord, 4'h0};
					next_driving = 1'b1;
				end else if (fifoMode && nibble != afs_pkg::CMD_READ_FIFO)
					next_driving = 1'b0;
				if (intServe && nibble != afs_pkg::CMD_READ_FIFO
					&& nibble != afs_pkg::CMD_CONFIG)
					next_stale = 1'b1;
			end
		end
		// Whole word decode
		if (wordDone) begin
			if (word == afs_pkg::WORD_HOST_SEL)
				next_hostSelected = 1'b1;
			else if (cfgWrite) begin
				next_configWord = word[11:0];
				next_intActive = 1'b0;
				next_intPending = 1'b0;
				next_stale = 1'b0;
				next_seqIdx = '0;
				next_armed = word[afs_pkg::CFG_MODE_LSB + 1];
			end else if (word[15:12] == afs_pkg::CMD_SLEEP)
				next_swSleep = 1'b1;
			else if (!word[15]) begin
				next_chan = word[14:12];
				next_armed = 1'b1;
			end
		end
		// Repeat sweep rearms once the host has drained the FIFO
		if (fifoPop && fifoCount == 4'h1 && mode == afs_pkg::MODE_RSWEEP) begin
			next_armed = 1'b1;
			next_seqIdx = '0;
		end
		// Conversion engine, timed by the serial clock
		case (convState)
			afs_pkg::CONV_IDLE: begin
				if (armed && awake && (fifoInReady || !fifoMode)
					&& (configWord[afs_pkg::CFG_EXT_BIT]
					? (trigRise && chipSelN)
					: (fifoMode ? frameStart : csRise))) begin
					next_convState = afs_pkg::CONV_RUN;
					next_convCnt = '0;
					next_sampleChannel = mode[1]
						? afs_pkg::seqChan(configWord[afs_pkg::CFG_SEQ_LSB +: 2],
						seqIdx) : chan;
				end
			end
			afs_pkg::CONV_RUN: begin
				if (convDone) begin
					next_convState = afs_pkg::CONV_IDLE;
					next_firstInvalid = wakeFirst;
					next_wakeFirst = 1'b0;
					if (mode[1])
						next_seqIdx = seqIdx + 3'h1;
					if (!fifoMode) begin
						next_lastResult = adcResult;
						next_intActive = 1'b1;
						next_armed = 1'b0;
					end else if ((stale ? 4'h1 : fifoCount + 4'h1)
						== afs_pkg::thrCount(configWord[1:0])) begin
						next_intActive = 1'b1;
						next_intPending = 1'b1;
						next_armed = 1'b0;
					end
				end else if (sclkRise)
					next_convCnt = convCnt + 6'h01;
			end
			default: next_convState = afs_pkg::CONV_IDLE;
		endcase
		// Sleep aborts work but keeps the configuration
		if (!awake) begin
			next_convState = afs_pkg::CONV_IDLE;
			next_seqIdx = '0;
			next_intPending = 1'b0;
			next_wakeFirst = 1'b1;
			if (hwSleepPin)
				next_recovCnt = 20'(RECOVERY_CYCLES);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclkQ <= 1'b0;
			csQ <= 1'b1;
			fsQ <= 1'b0;
			trigQ <= 1'b1;
			bitCnt <= '0;
			inShift <= '0;
			outShift <= '0;
			driving <= 1'b0;
			intServe <= 1'b0;
			intActive <= 1'b0;
			intPending <= 1'b0;
			armed <= 1'b0;
			stale <= 1'b0;
			swSleep <= 1'b0;
			wakeFirst <= 1'b1;
			chan <= '0;
			seqIdx <= '0;
			sampleChannel <= '0;
			convState <= afs_pkg::CONV_IDLE;
			convCnt <= '0;
			lastResult <= '0;
			configWord <= afs_pkg::CFG_RESET;
			firstResultInvalid <= 1'b0;
			hostSelected <= 1'b0;
			recovCnt <= '0;
		end else begin
			sclkQ <= sclk;
			csQ <= chipSelN;
			fsQ <= frameSync;
			trigQ <= conversionTriggerN;
			bitCnt <= next_bitCnt;
			inShift <= next_inShift;
			outShift <= next_outShift;
			driving <= next_driving;
			intServe <= next_intServe;
			intActive <= next_intActive;
			intPending <= next_intPending;
			armed <= next_armed;
			stale <= next_stale;
			swSleep <= next_swSleep;
			wakeFirst <= next_wakeFirst;
			chan <= next_chan;
			seqIdx <= next_seqIdx;
			sampleChannel <= next_sampleChannel;
			convState <= next_convState;
			convCnt <= next_convCnt;
			lastResult <= next_lastResult;
			configWord <= next_configWord;
			firstResultInvalid <= next_firstInvalid;
			hostSelected <= next_hostSelected;
			recovCnt <= next_recovCnt;
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_CFG_FLUSH: assert property (cfgWrite |=> fifoCount == 4'h0)
		else $error("config write left data in fifo");
	AST_CFG_NO_INT: assert property (cfgWrite |=> intN)
		else $error("config write raised interrupt");
	AST_MODE_FIELD: assert property (cfgWrite |=> mode == $past(word[6:5]))
		else $error("mode field not taken from bits 6:5");
	AST_INT_AT_THR: assert property ($fell(intN) && fifoMode
		|-> fifoCount == afs_pkg::thrCount(configWord[1:0]))
		else $error("interrupt not at threshold");
	AST_HALF_FOUR: assert property ($fell(intN) && fifoMode
		&& configWord[1:0] == 2'b10 |-> fifoCount == 4'h4)
		else $error("half threshold is not four");
	AST_INT_CLEAR: assert property (frameStart && !cfgWrite
		&& !convDone |=> intN)
		else $error("interrupt kept after chip select");
	AST_CONV_LEN: assert property (convDone && !configWord[2]
		|-> convCnt == 6'd17)
		else $error("divide-by-one conversion not 18 clocks");
	AST_DIV_TWO: assert property (convDone && configWord[2]
		|-> convCnt == 6'd31)
		else $error("divide-by-two conversion not 32 clocks");
	AST_AUTO_PD: assert property (awake && chipSelN && conversionTriggerN
		&& convState == afs_pkg::CONV_IDLE |-> !converterOn && referenceOn)
		else $error("auto power-down wrong");
	AST_SW_SLEEP: assert property (wordDone
		&& word == afs_pkg::WORD_SW_SLEEP |=> !referenceOn ##1 fifoCount == 4'h0)
		else $error("software sleep not entered");
	AST_HW_SLEEP: assert property (hwSleepPin |=> !converterOn
		&& convState == afs_pkg::CONV_IDLE)
		else $error("hardware sleep ignored");
	AST_CFG_KEPT: assert property (hwSleepPin && !cfgWrite
		|=> $stable(configWord) && seqIdx == 3'h0)
		else $error("sleep changed config or sequence");
	AST_SLEEP_FLUSH: assert property (hwSleepPin |=> fifoCount == 4'h0)
		else $error("sleep kept fifo data");
	AST_RESWEEP: assert property (fifoPop && fifoCount == 4'h1
		&& mode == afs_pkg::MODE_RSWEEP && awake && !cfgWrite |=> armed)
		else $error("repeat sweep not rearmed");
	AST_FIRST_BAD: assert property (convDone && wakeFirst
		|=> firstResultInvalid)
		else $error("first conversion not flagged");
	AST_SPEC_READ: assert property (frameStart && fifoMode
		&& fifoOutValid |=> !serialOutEnN ##0 serialOut == $past(fifoHead[11]))
		else $error("fifo head not driven at frame start");
	AST_STALE: assert property (stale && fifoPush && awake && !cfgWrite
		|=> fifoCount == 4'h1)
		else $error("unread fifo not cleared");
	AST_EDGE: assert property (inFrame && csAsFrame && !sclkRise
		&& !frameStart |=> $stable(inShift))
		else $error("sampled off the rising edge");

	COV_THR: cover property ($fell(intN) && fifoMode);
	COV_READ: cover property (fifoPop ##[1:200] fifoCount == 4'h0);
	COV_SLEEP: cover property (swSleep ##[1:100] !swSleep);
endmodule // afs_sequencer

// ===== tb/afs_host_model.sv
`timescale 1ns/1ps
// Host serial port: sends 16-bit frames MSB first, free clocks on request
module afs_host_model #(
	parameter int HALF = 6
) (
	// Clock
	input  wire logic ref_clk,
	// Serial link
	output logic      sclk,
	output logic      chipSelN,
	output logic      serialIn,
	input  wire logic serialOut
);
	// Idle levels at time zero
	initial begin
		sclk     = 1'b0;
		chipSelN = 1'b1;
		serialIn = 1'b0;
	end

	// One frame; data moves mid-low so either sampling edge sees it stable
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		r = 16'h0000;
		@(posedge ref_clk);
		chipSelN <= 1'b0;
		serialIn <= w[15];
		repeat (HALF) @(posedge ref_clk);
		for (int i = 15; i >= 0; i--) begin
			sclk <= 1'b1;
			repeat (HALF) @(posedge ref_clk);
			sclk <= 1'b0;
			r[i] = serialOut;
			repeat (3) @(posedge ref_clk);
			// Released line shows the inverse, never a stale bit
			serialIn <= (i > 0) ? w[i-1] : ~w[0];
			repeat (HALF - 3) @(posedge ref_clk);
		end
		chipSelN <= 1'b1;
		repeat (HALF) @(posedge ref_clk);
	endtask

	// Deselected clocks; conversions are timed from sclk, so it must run
	task automatic idle(input int n);
		repeat (n) begin
			sclk <= 1'b1;
			repeat (HALF) @(posedge ref_clk);
			sclk <= 1'b0;
			repeat (HALF) @(posedge ref_clk);
		end
	endtask
endmodule // afs_host_model

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
	localparam int LIMIT = 90000;
	// Design ports
	logic        ref_clk;
	logic        rst;
	logic        sclk;
	logic        chipSelN;
	logic        csAsFrame;
	logic        serialIn;
	logic        serialOut;
	logic        serialOutEnN;
	logic        hwSleepPin;
	logic [11:0] adcResult;
	logic [2:0]  sampleChannel;
	logic        converterOn;
	logic        referenceOn;
	logic        intN;
	logic        firstResultInvalid;
	logic        recovered;
	logic        hostSelected;
	logic [11:0] configWord;
	// Bench state
	logic [15:0] rd;
	int          mismatches = 0;
	int          compares = 0;

	afs_sequencer #(.RECOVERY_CYCLES(20)) dut (
		.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .chipSelN(chipSelN),
		.frameSync(1'b0), .csAsFrame(csAsFrame), .serialIn(serialIn),
		.serialOut(serialOut), .serialOutEnN(serialOutEnN),
		.conversionTriggerN(1'b1), .hwSleepPin(hwSleepPin),
		.adcResult(adcResult), .sampleChannel(sampleChannel),
		.converterOn(converterOn), .referenceOn(referenceOn), .intN(intN),
		.firstResultInvalid(firstResultInvalid), .recovered(recovered),
		.hostSelected(hostSelected), .configWord(configWord));

	afs_host_model host (
		.ref_clk(ref_clk), .sclk(sclk), .chipSelN(chipSelN),
		.serialIn(serialIn), .serialOut(serialOut));

	// 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// Entries that raise the interrupt
	function automatic int expThr(input logic [1:0] th);
		return (th == 2'b00) ? 8 : (th == 2'b01) ? 6 : (th == 2'b10) ? 4 : 2;
	endfunction

	// Idle sclk rises after a 16-clock frame until a result lands
	function automatic int need(input logic dv);
		return 4 + 14 * (dv ? 2 : 1) - 16;
	endfunction

	// Configuration value: sequence 0-1-2-3, normal sampling
	function automatic logic [11:0] cw(input logic [1:0] md,
		input logic dv, input logic [1:0] th);
		return {5'h00, md, 2'b00, dv, th};
	endfunction

	// Flag and word comparisons
	task automatic chkB(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: flag %b, want %b", $time, got, exp);
		end
	endtask

	task automatic chkW(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: word %h, want %h", $time, got, exp);
		end
	endtask

	// Single exit for normal end and timeout
	task automatic close_out();
		if (mismatches == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Configuration write, random sampling edge
	task automatic cfg(input logic [11:0] w);
		csAsFrame <= 1'($urandom_range(1));
		host.xfer({4'hA, w}, rd);
		csAsFrame <= 1'b0;
		chkW({4'h0, configWord}, {4'h0, w});
		chkB(intN, 1'b1);
	endtask

	// n triggered conversions; last one lands exactly on time if hit
	task automatic convs(input int n, input logic dv, input logic hit);
		for (int k = 1; k <= n; k++) begin
			host.xfer(16'h9000, rd);
			if (k == n && hit) begin
				host.idle(need(dv) - 1);
				chkB(intN, 1'b1);
				host.idle(1);
				chkB(intN, 1'b0);
			end else begin
				host.idle(need(dv) + 1);
				chkB(intN, 1'b1);
			end
		end
	endtask

	// FIFO reads; first frame also drops the interrupt
	task automatic drain(input int n);
		for (int k = 0; k < n; k++) begin
			host.xfer(16'hE000, rd);
			chkW(rd, {adcResult, 4'h0});
			chkB(intN, 1'b1);
		end
	endtask

	// One mode, two passes: second pass proves rearm or its absence
	task automatic batch(input logic [1:0] md);
		logic [1:0] th;
		logic       dv;
		logic [2:0] ch;
		int         t;
		th = 2'($urandom_range(3));
		dv = 1'($urandom_range(1));
		ch = 3'($urandom);
		t = expThr(th);
		adcResult <= 12'($urandom);
		cfg(cw(md, dv, th));
		for (int p = 0; p < 2; p++) begin
			if (md == 2'b01)
				host.xfer({1'b0, ch, 12'h000}, rd);
			convs(t, dv, md != 2'b10 || p == 0);
			if (md == 2'b01)
				chkW({13'h0000, sampleChannel}, {13'h0000, ch});
			if (md != 2'b10 || p == 0)
				drain(t);
		end
	endtask

	// Single shot: select arms, conversion runs after chip select rises
	task automatic single();
		logic       dv;
		logic [2:0] ch;
		dv = 1'($urandom_range(1));
		ch = 3'($urandom);
		adcResult <= 12'($urandom);
		cfg(cw(2'b00, dv, 2'b00));
		host.xfer({1'b0, ch, 12'h000}, rd);
		host.idle(4 + 14 * (dv ? 2 : 1));
		chkB(intN, 1'b0);
		chkW({13'h0000, sampleChannel}, {13'h0000, ch});
		csAsFrame <= 1'($urandom_range(1));
		host.xfer(16'hE000, rd);
		csAsFrame <= 1'b0;
		chkW(rd, {adcResult, 4'h0});
		chkB(intN, 1'b1);
	endtask

	// Leave one stale entry, disturb, then count to threshold afresh
	task automatic discard(input int kind);
		logic        dv;
		logic [11:0] w;
		dv = 1'($urandom_range(1));
		w = cw(2'b11, dv, 2'b11);
		adcResult <= 12'($urandom);
		cfg(w);
		convs(1, dv, 1'b0);
		case (kind)
			0: cfg(w);
			1: begin
				host.xfer(16'h8000, rd);
				chkB(referenceOn, 1'b0);
				host.xfer(16'h9000, rd);
			end
			default: begin
				hwSleepPin <= 1'b1;
				repeat (3) @(posedge ref_clk);
				chkB(referenceOn, 1'b0);
				chkB(converterOn, 1'b0);
				hwSleepPin <= 1'b0;
				repeat (2) @(posedge ref_clk);
				chkB(recovered, 1'b0);
			end
		endcase
		chkW({4'h0, configWord}, {4'h0, w});
		repeat (30) @(posedge ref_clk);
		chkB(recovered, 1'b1);
		convs(1, dv, 1'b0);
		chkB(firstResultInvalid, 1'(kind != 0));
		if (kind != 0)
			chkW({13'h0000, sampleChannel}, 16'h0000);
		convs(1, dv, 1'b1);
		chkB(firstResultInvalid, 1'b0);
		drain(2);
		chkB(converterOn, 1'b0);
		chkB(referenceOn, 1'b1);
	endtask

	// Main sequence
	initial begin
		rst = 1'b1;
		csAsFrame = 1'b0;
		hwSleepPin = 1'b0;
		adcResult = 12'h000;
		void'($urandom(32'hca7f));
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chkB(intN, 1'b1);
		chkB(serialOutEnN, 1'b1);
		chkB(hostSelected, 1'b0);
		chkW({4'h0, configWord}, 16'h0000);
		host.xfer(16'hA000, rd);
		chkB(hostSelected, 1'b1);
		single();
		for (int m = 1; m < 4; m++)
			batch(2'(m));
		for (int k = 0; k < 3; k++)
			discard(k);
		close_out();
	end

	// Hang guard, about four times the expected run
	initial begin
		repeat (LIMIT) @(posedge ref_clk);
		mismatches++;
		close_out();
	end
endmodule // tb
